// ---- wbm_port.sv ----
/*
  workspace byte memory port: splits core word accesses into byte cycles on
  an 8-bit external bus, forms workspace register addresses and runs the
  context switch (five accesses on call, three on return).
  assumes the core holds its request stable until done_out, and that
  ready_in and hold_n_in come from outside and need synchronising.
*/
`timescale 1ns/1ps
`default_nettype none
module wbm_port
  import wbm_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic req_valid_in,
  input wire wbm_req_t req_in,
  output logic busy_out,
  output logic done_out,
  output wbm_rsp_t rsp_out,
  output logic [15:0] addr_out,
  output logic [7:0] data_out,
  output logic data_oe_out,
  input wire logic [7:0] data_in,
  output logic memory_cycle_enable_n_out,
  output logic data_in_strobe_n_out,
  output logic write_strobe_n_out,
  output logic opcode_fetch_or_hold_ack_out,
  input wire logic ready_in,
  input wire logic hold_n_in
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic rdy_s1_q, rdy_q, hold_s1_q, hold_n_q;

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      rdy_s1_q <= 1'b0;
      rdy_q <= 1'b0;
      hold_s1_q <= 1'b1;
      hold_n_q <= 1'b1;
    end
    else
    begin
      rdy_s1_q <= ready_in;
      rdy_q <= rdy_s1_q;
      hold_s1_q <= hold_n_in;
      hold_n_q <= hold_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // sequencing state
  // ---------------------------------------------------------------
  wbm_state_t state_q, state_d;
  logic [15:0] wp_q, pc_q, st_q;
  logic [15:0] base_q;
  logic [15:0] wword_q, rword_q;
  logic second_q, byte_q, write_q, opc_q, hold_q;
  logic [2:0] step_q;
  logic ctx_q, ret_q;
  logic [15:0] old_wp_q, old_pc_q, old_st_q;

  // workspace register address, forced even
  function automatic logic [15:0] ws_addr(input logic [15:0] wp, input logic [3:0] n);
    ws_addr = (wp & WBM_EVEN_MASK) + {11'h000, n, 1'b0};
  endfunction : ws_addr

  // context switch step: call loads wp,pc from vector then saves 13..15 in the new workspace;
  // return loads 13..15 of the current workspace instead
  logic [15:0] ctx_addr;
  logic ctx_wr;
  logic [15:0] ctx_wdata;

  always_comb
  begin
    ctx_addr = 16'h0000;
    ctx_wr = 1'b0;
    ctx_wdata = 16'h0000;
    if (!ret_q)
    begin
      case (step_q)
        3'd0: ctx_addr = base_q; // vector word 0: new wp
        3'd1: ctx_addr = base_q + 16'h0002; // vector word 1: new pc
        3'd2:
        begin
          ctx_addr = ws_addr(wp_q, WBM_REG_OLD_WP);
          ctx_wr = 1'b1;
          ctx_wdata = old_wp_q;
        end
        3'd3:
        begin
          ctx_addr = ws_addr(wp_q, WBM_REG_OLD_PC);
          ctx_wr = 1'b1;
          ctx_wdata = old_pc_q;
        end
        default:
        begin
          ctx_addr = ws_addr(wp_q, WBM_REG_OLD_ST);
          ctx_wr = 1'b1;
          ctx_wdata = old_st_q;
        end
      endcase
    end
    else
    begin
      case (step_q)
        3'd0: ctx_addr = ws_addr(wp_q, WBM_REG_OLD_ST);
        3'd1: ctx_addr = ws_addr(wp_q, WBM_REG_OLD_PC);
        default: ctx_addr = ws_addr(wp_q, WBM_REG_OLD_WP);
      endcase
    end
  end

  logic ctx_last;
  assign ctx_last = ret_q ? (step_q == 3'd2) : (step_q == 3'd4);

  // ---------------------------------------------------------------
  // main sequencer
  // ---------------------------------------------------------------
  logic [1:0] xfer_age_q;
  logic cycle_end;
  // ready lags two flops; early transfer cycles still see the last strobe's answer
  assign cycle_end = (state_q == WBM_S_XFER) && rdy_q
                     && (xfer_age_q == WBM_RDY_SETTLE);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      WBM_S_IDLE:
      begin
        if (req_valid_in && hold_n_q)
        begin
          state_d = (req_in.op == WBM_OP_CTX) ? WBM_S_CTX : WBM_S_GAP;
        end
      end
      WBM_S_CTX: state_d = WBM_S_ADDR;
      WBM_S_GAP: state_d = WBM_S_ADDR; // lets the taken address and data settle first
      WBM_S_ADDR: state_d = WBM_S_XFER;
      WBM_S_XFER:
      begin
        if (cycle_end)
        begin
          if (!byte_q && !second_q)
          begin
            state_d = WBM_S_ADDR; // no hold between bytes
          end
          else if (ctx_q && !ctx_last)
          begin
            state_d = WBM_S_CTX;
          end
          else
          begin
            state_d = WBM_S_DONE;
          end
        end
      end
      WBM_S_DONE: state_d = WBM_S_IDLE;
      default: state_d = WBM_S_IDLE;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      state_q <= WBM_S_IDLE;
      xfer_age_q <= 2'h0;
    end
    else
    begin
      state_q <= state_d;
      xfer_age_q <= (state_q != WBM_S_XFER) ? 2'h0
                    : xfer_age_q + 2'(xfer_age_q != WBM_RDY_SETTLE);
    end
  end

  // hold acknowledge only between whole accesses
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      hold_q <= 1'b0;
    end
    else
    begin
      hold_q <= (state_d == WBM_S_IDLE) && !hold_n_q;
    end
  end

  // ---------------------------------------------------------------
  // access setup and byte pairing
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      base_q <= 16'h0000;
      wword_q <= 16'h0000;
      byte_q <= 1'b0;
      write_q <= 1'b0;
      opc_q <= 1'b0;
      second_q <= 1'b0;
      ctx_q <= 1'b0;
      ret_q <= 1'b0;
      step_q <= 3'd0;
      old_wp_q <= 16'h0000;
      old_pc_q <= 16'h0000;
      old_st_q <= 16'h0000;
    end
    else if (state_q == WBM_S_IDLE && state_d != WBM_S_IDLE)
    begin
      ctx_q <= (req_in.op == WBM_OP_CTX);
      ret_q <= req_in.ctx_return;
      step_q <= 3'd0;
      second_q <= 1'b0;
      opc_q <= req_in.opcode && !req_in.write;
      old_wp_q <= wp_q;
      old_pc_q <= pc_q;
      old_st_q <= req_in.st;
      write_q <= req_in.write;
      wword_q <= req_in.wdata;
      if (req_in.op == WBM_OP_REG)
      begin
        base_q <= ws_addr(wp_q, req_in.reg_num);
        byte_q <= req_in.byte_acc; // even address = high byte
      end
      else if (req_in.op == WBM_OP_CTX)
      begin
        base_q <= req_in.addr & WBM_EVEN_MASK;
        byte_q <= 1'b0;
      end
      else
      begin
        // word at odd address uses the even address below
        base_q <= req_in.byte_acc ? req_in.addr : (req_in.addr & WBM_EVEN_MASK);
        byte_q <= req_in.byte_acc;
      end
    end
    else if (state_q == WBM_S_CTX)
    begin
      second_q <= 1'b0;
      opc_q <= 1'b0;
      write_q <= ctx_wr;
      wword_q <= ctx_wdata;
    end
    else if (cycle_end)
    begin
      if (!byte_q && !second_q)
      begin
        second_q <= 1'b1; // odd byte follows
      end
      else if (ctx_q)
      begin
        step_q <= step_q + 3'd1;
      end
    end
  end

  // ---------------------------------------------------------------
  // bus pins
  // ---------------------------------------------------------------
  logic [15:0] cyc_addr;
  assign cyc_addr = (state_q == WBM_S_CTX) ? ctx_addr : base_q;

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      addr_out <= 16'h0000;
      data_out <= 8'h00;
    end
    else if (state_d == WBM_S_ADDR)
    begin
      if (state_q == WBM_S_XFER)
      begin
        addr_out <= {addr_out[15:1], 1'b1};
        data_out <= wword_q[7:0]; // low byte at odd address
      end
      else
      begin
        addr_out <= cyc_addr;
        data_out <= byte_q ? (cyc_addr[0] ? wword_q[7:0] : wword_q[15:8])
                           : (state_q == WBM_S_CTX ? ctx_wdata[15:8] : wword_q[15:8]);
      end
    end
  end

  logic active;
  assign active = (state_q == WBM_S_ADDR) || (state_q == WBM_S_XFER);

  // enable stays low from first address until the access ends
  assign memory_cycle_enable_n_out = !(active || state_q == WBM_S_CTX);
  assign data_in_strobe_n_out = !((state_q == WBM_S_XFER) && !write_q);
  assign write_strobe_n_out = !((state_q == WBM_S_XFER) && write_q);
  assign data_oe_out = active && write_q && !hold_q; // released for reads
  assign opcode_fetch_or_hold_ack_out = (active && opc_q) || hold_q;

  // ---------------------------------------------------------------
  // read capture and processor context
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      rword_q <= 16'h0000;
    end
    else if (cycle_end && !write_q)
    begin
      if (byte_q)
      begin
        rword_q <= {data_in, 8'h00}; // addressed byte in high half
      end
      else if (!second_q)
      begin
        rword_q[15:8] <= data_in;
      end
      else
      begin
        rword_q[7:0] <= data_in;
      end
    end
  end

  logic word_done;
  assign word_done = cycle_end && (byte_q || second_q) && !write_q;

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      wp_q <= WBM_WP_RESET;
      pc_q <= 16'h0000;
      st_q <= 16'h0000;
    end
    else if (ctx_q && word_done)
    begin
      case (step_q)
        3'd0:
        begin
          if (ret_q)
          begin
            st_q <= {rword_q[15:8], data_in};
          end
          else
          begin
            wp_q <= {rword_q[15:8], data_in} & WBM_EVEN_MASK;
          end
        end
        3'd1: pc_q <= {rword_q[15:8], data_in} & WBM_EVEN_MASK;
        default: wp_q <= {rword_q[15:8], data_in} & WBM_EVEN_MASK;
      endcase
    end
    else if (state_q == WBM_S_IDLE && req_valid_in && req_in.op == WBM_OP_MEM && req_in.opcode)
    begin
      pc_q <= req_in.addr & WBM_EVEN_MASK;
    end
  end

  assign busy_out = (state_q != WBM_S_IDLE);
  assign done_out = (state_q == WBM_S_DONE);
  assign rsp_out = '{rdata: rword_q, wp: wp_q, pc: pc_q, st: st_q};

endmodule : wbm_port
`default_nettype wire

// ---- wbm_pkg.sv ----
/*
  package for the workspace byte memory port: request and answer carriers,
  workspace register numbers, state codes, the even address mask and the ready settle count.
  assumes a single 20 MHz clock domain and a byte-wide external bus.
*/
package wbm_pkg;

  localparam int WBM_WS_WORDS = 16;
  localparam logic [3:0] WBM_REG_MSW = 4'h0;
  localparam logic [3:0] WBM_REG_LSW = 4'h1;
  localparam logic [3:0] WBM_REG_LINK = 4'hb;
  localparam logic [3:0] WBM_REG_SERIAL = 4'hc;
  localparam logic [3:0] WBM_REG_OLD_WP = 4'hd;
  localparam logic [3:0] WBM_REG_OLD_PC = 4'he;
  localparam logic [3:0] WBM_REG_OLD_ST = 4'hf;
  localparam logic [15:0] WBM_WP_RESET = 16'h0000;
  localparam logic [15:0] WBM_EVEN_MASK = 16'hfffe;
  // transfer cycles that ignore ready while its synchroniser still shows the last strobe
  localparam logic [1:0] WBM_RDY_SETTLE = 2'h2;

  // access kinds a core request may ask for
  typedef enum logic [2:0]
  {
    WBM_OP_MEM = 3'b001,
    WBM_OP_REG = 3'b010,
    WBM_OP_CTX = 3'b100
  } wbm_op_t;

  typedef enum logic [7:0]
  {
    WBM_S_IDLE = 8'b0000_0001,
    WBM_S_ADDR = 8'b0000_0010,
    WBM_S_XFER = 8'b0000_0100,
    WBM_S_NEXT = 8'b0000_1000,
    WBM_S_CTX = 8'b0001_0000,
    WBM_S_DONE = 8'b0010_0000,
    WBM_S_GAP = 8'b0100_0000,
    WBM_S_SPARE = 8'b1000_0000
  } wbm_state_t;

  typedef struct packed
  {
    wbm_op_t op;
    logic write;
    logic byte_acc;
    logic opcode;
    logic [15:0] addr;
    logic [3:0] reg_num;
    logic [15:0] wdata;
    logic [15:0] new_wp;
    logic [15:0] new_pc;
    logic [15:0] st;
    logic ctx_return;
  } wbm_req_t;

  typedef struct packed
  {
    logic [15:0] rdata;
    logic [15:0] wp;
    logic [15:0] pc;
    logic [15:0] st;
  } wbm_rsp_t;

endpackage : wbm_pkg

// ---- wbm_port_monitor.sv ----
/* checker for wbm_port byte cycle sequencing, bound to the port.
   assumes wbm_pkg is compiled first and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module wbm_port_monitor
  import wbm_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire wbm_req_t req_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire wbm_rsp_t rsp_out,
  input wire logic [15:0] addr_out,
  input wire logic data_oe_out,
  input wire logic memory_cycle_enable_n_out,
  input wire logic data_in_strobe_n_out,
  input wire logic write_strobe_n_out,
  input wire logic opcode_fetch_or_hold_ack_out,
  input wire logic ready_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  wire logic xfer = !(data_in_strobe_n_out && write_strobe_n_out);
  wire logic mem_op = req_in.op == WBM_OP_MEM;

  rd_bus_free_a:
    assert property (!data_in_strobe_n_out |-> !data_oe_out && !memory_cycle_enable_n_out
      && write_strobe_n_out) else $error("read strobe with bus driven");
  wr_data_on_a:
    assert property (!write_strobe_n_out |-> data_oe_out && !memory_cycle_enable_n_out)
      else $error("write strobe without data or enable");
  addr_first_a:
    assert property ($fell(data_in_strobe_n_out) || $fell(write_strobe_n_out)
      |-> $stable(addr_out)) else $error("address moved with strobe");
  byte_addr_a:
    assert property (xfer && mem_op && req_in.byte_acc |-> addr_out == req_in.addr)
      else $error("byte cycle at wrong address");
  word_addr_a:
    assert property (xfer && mem_op && !req_in.byte_acc
      |-> addr_out[15:1] == req_in.addr[15:1]) else $error("word cycle off its word");
  reg_addr_a:
    assert property (xfer && req_in.op == WBM_OP_REG
      |-> addr_out[15:1] == rsp_out.wp[15:1] + 15'(req_in.reg_num))
      else $error("register address wrong");
  opcode_rd_a:
    assert property (!memory_cycle_enable_n_out && opcode_fetch_or_hold_ack_out
      |-> req_in.opcode && !req_in.write) else $error("opcode flag on non-opcode cycle");
  ready_wait_a:
    assert property ((!data_in_strobe_n_out && !ready_in) [*3] |=> !data_in_strobe_n_out)
      else $error("read ended without ready");
  no_hold_mid_a:
    assert property (busy_out |-> !(memory_cycle_enable_n_out && opcode_fetch_or_hold_ack_out))
      else $error("hold granted inside an access");
  done_bound_a:
    assert property ($rose(busy_out) |-> ##[3:200] done_out) else $error("access never ended");
endmodule : wbm_port_monitor

bind wbm_port wbm_port_monitor wbm_port_monitor_inst (.clk_in, .resetn_in, .req_in,
  .busy_out, .done_out, .rsp_out, .addr_out, .data_oe_out, .memory_cycle_enable_n_out,
  .data_in_strobe_n_out, .write_strobe_n_out, .opcode_fetch_or_hold_ack_out, .ready_in);
`default_nettype wire

// ---- wbm_mem_model.sv ----
/* byte-wide memory on the far side of wbm_port, with optional slow ready.
   assumes active-low enable and strobes on the one clock. */
`timescale 1ns/1ps
`default_nettype none
module wbm_mem_model
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic slow_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic data_oe_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic en_n_in,
  output logic [7:0] rdata_out,
  output logic ready_out
);
  logic [7:0] mem [65536];
  logic [7:0] last_q;
  logic [1:0] wait_q;
  wire logic strobe = !(rd_n_in && wr_n_in) && !en_n_in;

  initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'(i >> 8);
  // slow mode holds ready low for three cycles of each strobe
  assign ready_out = !slow_in || wait_q == 2'h3;
  // a released bus never repeats its last byte, so a late sample shows
  assign rdata_out = (!rd_n_in && !en_n_in) ? mem[addr_in] : ~last_q;
  always @(posedge clk_in)
  begin
    last_q <= resetn_in ? rdata_out : 8'h5a;
    wait_q <= (!resetn_in || !strobe) ? 2'h0 : wait_q + 2'(wait_q != 2'h3);
    if (strobe && !wr_n_in && data_oe_in && ready_out) mem[addr_in] <= wdata_in;
  end
endmodule : wbm_mem_model
`default_nettype wire

// ---- test_wbm_port.sv ----
/* bench for wbm_port: random and corner accesses against a byte memory.
   assumes wbm_pkg, the memory model and the checker compile first. */
`timescale 1ns/1ps
`default_nettype none
module test_wbm_port;
  import wbm_pkg::*;
  logic clk_in = 0, resetn_in = 0, req_valid_in = 0, hold_n_in = 1, slow = 0;
  wbm_req_t req_in = '0;
  wbm_rsp_t rsp_out, r;
  logic busy_out, done_out, data_oe_out, ready_in, opcode_fetch_or_hold_ack_out;
  logic memory_cycle_enable_n_out, data_in_strobe_n_out, write_strobe_n_out;
  logic [15:0] addr_out, wp_e = 0, pc_e = 0;
  logic [7:0] data_out, data_in;
  logic [7:0] m [65536];
  int fail_count = 0, check_count = 0, seed = 46;

  always #25 clk_in = ~clk_in;

  wbm_port wbm_port_inst (.clk_in, .resetn_in, .req_valid_in, .req_in, .busy_out, .done_out,
    .rsp_out, .addr_out, .data_out, .data_oe_out, .data_in, .memory_cycle_enable_n_out,
    .data_in_strobe_n_out, .write_strobe_n_out, .opcode_fetch_or_hold_ack_out, .ready_in,
    .hold_n_in);
  wbm_mem_model wbm_mem_model_inst (.clk_in, .resetn_in, .slow_in(slow), .addr_in(addr_out),
    .wdata_in(data_out), .data_oe_in(data_oe_out), .rd_n_in(data_in_strobe_n_out),
    .wr_n_in(write_strobe_n_out), .en_n_in(memory_cycle_enable_n_out),
    .rdata_out(data_in), .ready_out(ready_in));

  function automatic logic [15:0] wrd(input logic [15:0] a);
    return {m[a & 16'hfffe], m[a | 16'h0001]};
  endfunction : wrd

  function automatic logic [15:0] mdl(input logic [15:0] a);
    return {wbm_mem_model_inst.mem[a & 16'hfffe], wbm_mem_model_inst.mem[a | 16'h0001]};
  endfunction : mdl

  task automatic chk(input string s, input logic [15:0] g, e);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // request is held until the done pulse, then dropped at the next falling edge
  task automatic go(input wbm_op_t op, input logic wr, bt, input logic [15:0] a, wd,
    input logic [3:0] n, input logic ret);
    int k;
    @(negedge clk_in);
    slow = 1'($random(seed));
    req_in = '{op, wr, bt, ~wr & 1'($random(seed)), a, n, wd, 16'h0000, 16'h0000,
      16'($random(seed)), ret};
    req_valid_in = 1;
    k = 0;
    do
    begin
      @(posedge clk_in);
      #1;
      k++;
    end
    while (done_out !== 1'b1 && k < 400);
    r = rsp_out;
    if (k >= 400) fail_count++;
    @(negedge clk_in);
    req_valid_in = 0;
  endtask : go

  task automatic acc(input wbm_op_t op, input logic wr, bt, input logic [15:0] a,
    input logic [3:0] n);
    logic [15:0] ea, wd;
    wd = 16'($random(seed));
    ea = (op == WBM_OP_REG) ? wp_e + {11'h000, n, 1'b0} : a;
    go(op, wr, bt, a, wd, n, 0);
    if (wr && bt) m[ea] = ea[0] ? wd[7:0] : wd[15:8];
    if (wr && !bt) {m[ea & 16'hfffe], m[ea | 16'h0001]} = wd;
    if (wr) chk("mem", mdl(ea), wrd(ea));
    else if (bt) chk("rbyte", {r.rdata[15:8], 8'h00}, {m[ea], 8'h00});
    else chk("rword", r.rdata, wrd(ea));
  endtask : acc

  task automatic ctx(input logic ret, input logic [15:0] v);
    logic [15:0] nw, np;
    go(WBM_OP_CTX, 0, 0, v, 16'h0000, 4'h0, ret);
    if (ret)
    begin
      np = wrd(wp_e + 16'h001c);
      chk("st", r.st, wrd(wp_e + 16'h001e));
      nw = wrd(wp_e + 16'h001a) & WBM_EVEN_MASK;
    end
    else
    begin
      nw = wrd(v) & WBM_EVEN_MASK;
      np = wrd(v + 16'h0002);
      {m[nw + 16'h001a], m[nw + 16'h001b]} = wp_e;
      {m[nw + 16'h001c], m[nw + 16'h001d]} = pc_e;
      {m[nw + 16'h001e], m[nw + 16'h001f]} = req_in.st;
      for (int i = 26; i < 32; i += 2) chk("save", mdl(nw + 16'(i)), wrd(nw + 16'(i)));
    end
    wp_e = nw;
    pc_e = np;
    chk("wp", r.wp, wp_e);
    chk("pc", r.pc & WBM_EVEN_MASK, pc_e & WBM_EVEN_MASK);
  endtask : ctx

  initial
  begin
    for (int i = 0; i < 65536; i++) m[i] = 8'(i) ^ 8'(i >> 8);
    repeat (20) @(negedge clk_in);
    resetn_in = 1;
    @(negedge clk_in);
    chk("wp0", rsp_out.wp, WBM_WP_RESET);
    chk("addr0", addr_out, 16'h0000);
    ctx(0, 16'h0040);
    for (int j = 0; j < 32; j++) acc(WBM_OP_REG, j < 16, j[3], 16'h0000, 4'(j));
    fork
      acc(WBM_OP_MEM, 0, 0, 16'h1235, 4'h0);
      begin
        repeat (3) @(negedge clk_in);
        hold_n_in = 0;
      end
    join
    repeat (6) @(negedge clk_in);
    chk("hold_ack", {15'h0000, opcode_fetch_or_hold_ack_out}, 16'h0001);
    fork
      acc(WBM_OP_MEM, 1, 0, 16'h2001, 4'h0);
      begin
        repeat (8) @(negedge clk_in);
        chk("busy", {15'h0000, busy_out}, 16'h0000);
        hold_n_in = 1;
      end
    join
    repeat (80) acc(WBM_OP_MEM, 1'($random(seed)), 1'($random(seed)), 16'($random(seed)), 4'h0);
    ctx(1, 16'h0000);
    report_and_stop;
  end

  // a hung handshake ends the run through the same verdict
  initial
  begin
    #1_000_000;
    fail_count++;
    report_and_stop;
  end
endmodule : test_wbm_port
`default_nettype wire
